/* pkg/hub_pkg.sv */
`default_nettype none
package hub_pkg;
    // Port count and repeated symbol layout
    localparam int NUM_PORTS      = 4;
    localparam int SYM_WIDTH      = 3;     // {eop, plus, minus}
    localparam int SYM_EOP_BIT    = 2;
    localparam int SYM_PLUS_BIT   = 1;
    localparam int SYM_MINUS_BIT  = 0;
    localparam int FIFO_DEPTH     = 4;

    // Clocking of this block and of the link it stands for
    localparam longint CLK_HZ     = 10_000_000;
    localparam longint OSC_HZ     = 6_000_000;
    localparam longint PLL_HZ     = 48_000_000;
    localparam int PLL_MULT       = int'(PLL_HZ / OSC_HZ);
    localparam longint FS_BPS     = 12_000_000;
    localparam longint LS_BPS     = 1_500_000;
    localparam longint FRAME_CLK_HZ = 12_000_000;

    // Low-speed driver turn-on: four full-speed bit times, rounded down
    localparam longint LS_EN_BITS = 4;
    localparam longint LS_EN_NS   = (LS_EN_BITS * 1_000_000_000) / FS_BPS;
    localparam longint LS_EN_RAW  = (LS_EN_NS * CLK_HZ) / 1_000_000_000;
    localparam int LS_EN_CYCLES   = (LS_EN_RAW < 1) ? 1 : int'(LS_EN_RAW);

    // Frame length in microseconds and in block clocks
    localparam longint FRAME_US   = 1000;
    localparam int FRAME_CYCLES   = int'((FRAME_US * CLK_HZ) / 1_000_000);
    localparam int FRAME_WIDTH    = 14;

    // Reset values
    localparam logic [NUM_PORTS-1:0] PORTS_OFF_N = 4'hF;
    localparam logic [NUM_PORTS-1:0] PORTS_CLR   = 4'h0;

    typedef enum logic [1:0] {LS_IDLE, LS_ARM, LS_ON} ls_state_t;
endpackage
`default_nettype wire

/* logic/hub_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module hub_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstSync_n,
    // Filling side
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    // Draining side
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [AW:0]      count, next_count;
    logic             push, pop;

    // Full and empty follow the count register directly
    assign inReady  = (count != FULL_COUNT);
    assign outValid = (count != '0);
    assign outData  = store[rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // Pointer and occupancy next values
    always_comb begin
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_count = count;
        if (push) begin
            next_wrPtr = (wrPtr == LAST_IDX) ? '0 : wrPtr + 1'b1;
        end
        if (pop) begin
            next_rdPtr = (rdPtr == LAST_IDX) ? '0 : rdPtr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    // Storage has no reset; outData shows store[rdPtr] even while the FIFO is empty
    always_ff @(posedge clk) begin
        if (push) begin
            store[wrPtr] <= inData;
        end
    end
endmodule // hub_fifo
`default_nettype wire

/* logic/usb_hub_port_power_status.sv */
// Overview of operation
// - Repeat line states between upstream and all four downstream ports.
// - Full speed runs at 12 Mb/s, low speed at 1.5 Mb/s.
// - Reference is a 6 MHz oscillator multiplied to 48 MHz inside.
// - Power-source strap high means self-powered, low means bus-powered.
// - Self-powered reports local power sense; bus-powered ignores it.
// - Self-powered port power may be switched or permanently on.
// - Overcurrent and power control act per port or globally.
// - One active-low power-switch output per downstream port.
// - Overcurrent on a port switches that port's power off.
// - Overcurrent is latched and reported as status to the host.
// - Connect-status output asserted while the port is enabled.
// - Upstream packets go to enabled ports; downstream packets go upstream.
// - Low-speed ports only after preamble, drivers on within four bit times.
// - Frame timer restarts on every start-of-frame token.
`timescale 1ns/1ns
`default_nettype none
module usb_hub_port_power_status
    import hub_pkg::*;
#(
    parameter int FRAME_LEN = FRAME_CYCLES
) (
    // Clock and reset
    input  wire logic                 clk, // Stands in for 48 MHz
    input  wire logic                 arst_n,
    // Straps and configuration
    input  wire logic                 selfPowered,
    input  wire logic                 switchedMode,
    input  wire logic                 globalMode,
    input  wire logic                 testMode,
    input  wire logic                 local_power_sense,
    // Hub controller requests and status
    input  wire logic [NUM_PORTS-1:0] portPowerReq,
    input  wire logic [NUM_PORTS-1:0] portEnableReq,
    input  wire logic [NUM_PORTS-1:0] portLowSpeed,
    input  wire logic [NUM_PORTS-1:0] overcurrentClear,
    output logic      [NUM_PORTS-1:0] overcurrentStatus,
    output logic                      localPowerGood,
    // Serial engine events
    input  wire logic                 sofSeen,
    input  wire logic                 preambleSeen,
    output logic      [FRAME_WIDTH-1:0] frameTimer,
    // Port power pins
    input  wire logic [NUM_PORTS-1:0] port_overcurrent_n,
    output logic      [NUM_PORTS-1:0] port_power_switch_n,
    output logic      [NUM_PORTS-1:0] portConnectStatus_n,
    // Upstream port line state
    input  wire logic                 upstreamRxActive,
    input  wire logic                 upstreamEop,
    input  wire logic                 upstream_plus_in,
    input  wire logic                 upstream_minus_in,
    output logic                      upstream_plus_out,
    output logic                      upstream_minus_out,
    output logic                      upstreamOe_n,
    output logic                      upstreamFifoReady,
    // Downstream port line states
    input  wire logic                 downstreamTxReady,
    input  wire logic [NUM_PORTS-1:0] downstreamRxActive,
    input  wire logic [NUM_PORTS-1:0] downstream_plus_in,
    input  wire logic [NUM_PORTS-1:0] downstream_minus_in,
    output logic      [NUM_PORTS-1:0] downstream_plus_out,
    output logic      [NUM_PORTS-1:0] downstream_minus_out,
    output logic      [NUM_PORTS-1:0] downstreamOe_n
);
    localparam logic [FRAME_WIDTH-1:0] FRAME_LAST = FRAME_WIDTH'(FRAME_LEN-1);
    // Turn-on count follows from the full-speed bit rate
    localparam logic [2:0] LS_LAST = 3'(LS_EN_CYCLES - 1);
    localparam int LS_BOUND = LS_EN_CYCLES + 1;

    logic                 rstMeta, rstSync_n;
    logic [NUM_PORTS-1:0] ocMeta, ocSync;
    logic [NUM_PORTS-1:0] ocLatched, next_ocLatched;
    logic [NUM_PORTS-1:0] powerOn, portEnabled, getsTraffic;
    logic                 anyOc, fifoInReady, fifoValid, pop;
    logic [SYM_WIDTH-1:0] fifoData;
    ls_state_t            lsState, next_lsState;
    logic [2:0]           lsCount, next_lsCount;
    logic [FRAME_WIDTH-1:0] next_frameTimer;

    // Reset released through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta   <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta   <= 1'b1;
            rstSync_n <= rstMeta;
        end
    end

    // Overcurrent pins pass two flops before anything reads them
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            ocMeta <= PORTS_CLR;
            ocSync <= PORTS_CLR;
        end else begin
            ocMeta <= ~port_overcurrent_n;
            ocSync <= ocMeta;
        end
    end

    // Sticky overcurrent; a new event beats a clear in the same cycle
    always_comb begin
        next_ocLatched = (ocLatched & ~overcurrentClear) | ocSync;
    end
    assign anyOc = |ocLatched;

    // Power and enable per port, or one decision for all ports
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
        logic req, en, oc;
        assign req = globalMode ? portPowerReq[0] : portPowerReq[i];
        assign en  = globalMode ? portEnableReq[0] : portEnableReq[i];
        assign oc  = globalMode ? anyOc : ocLatched[i];
        // Bus-powered hubs always switch; self-powered may run unswitched
        assign powerOn[i] = !oc &&
            ((selfPowered && !switchedMode) || req);
        assign portEnabled[i] = powerOn[i] && en;
        // Low-speed ports only see traffic behind a preamble
        assign getsTraffic[i] = portEnabled[i] &&
            (!portLowSpeed[i] || lsState == LS_ON);
    end

    // Status, power and indicator outputs
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            ocLatched           <= PORTS_CLR;
            overcurrentStatus   <= PORTS_CLR;
            port_power_switch_n <= PORTS_OFF_N;
            portConnectStatus_n <= PORTS_OFF_N;
            localPowerGood      <= 1'b0;
        end else begin
            ocLatched           <= next_ocLatched;
            overcurrentStatus   <= globalMode ? {NUM_PORTS{anyOc}}
                                              : ocLatched;
            port_power_switch_n <= ~powerOn;
            portConnectStatus_n <= ~portEnabled;
            localPowerGood      <= selfPowered ? local_power_sense
                                               : 1'b1;
        end
    end

    // Low-speed driver window: armed by preamble, closed by end of packet
    always_comb begin
        next_lsState = lsState;
        next_lsCount = lsCount;
        case (lsState)
            LS_IDLE: begin
                next_lsCount = '0;
                if (preambleSeen) begin
                    next_lsState = LS_ARM;
                end
            end
            LS_ARM: begin
                next_lsCount = lsCount + 1'b1;
                if (lsCount >= LS_LAST - 3'd1 || LS_EN_CYCLES == 1) begin
                    next_lsState = LS_ON;
                end
            end
            LS_ON: begin
                if (pop && fifoData[SYM_EOP_BIT]) begin
                    next_lsState = LS_IDLE;
                end
            end
            default: next_lsState = LS_IDLE;
        endcase
    end

    // Frame timer restarts on start of frame, wraps at frame length
    always_comb begin
        if (sofSeen || frameTimer == FRAME_LAST) begin
            next_frameTimer = '0;
        end else begin
            next_frameTimer = frameTimer + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            lsState    <= LS_IDLE;
            lsCount    <= '0;
            frameTimer <= '0;
        end else begin
            lsState    <= next_lsState;
            lsCount    <= next_lsCount;
            frameTimer <= next_frameTimer;
        end
    end

    // Upstream symbols queue here; a slow drain backs up the receiver
    hub_fifo #(.WIDTH(SYM_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rstSync_n (rstSync_n),
        .inValid   (upstreamRxActive),
        .inData    ({upstreamEop, upstream_plus_in, upstream_minus_in}),
        .inReady   (fifoInReady),
        .outValid  (fifoValid),
        .outData   (fifoData),
        .outReady  (downstreamTxReady)
    );
    assign pop = fifoValid && downstreamTxReady;

    // Downstream-to-upstream: lowest enabled active port wins
    logic           upActive, upPlus, upMinus;
    always_comb begin
        upActive = 1'b0;
        upPlus   = 1'b0;
        upMinus  = 1'b0;
        for (int k = NUM_PORTS - 1; k >= 0; k--) begin
            if (downstreamRxActive[k] && portEnabled[k]) begin
                upActive = 1'b1;
                upPlus   = downstream_plus_in[k];
                upMinus  = downstream_minus_in[k];
            end
        end
    end

    // Line drivers, always on full-speed rate upstream
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            downstream_plus_out  <= PORTS_CLR;
            downstream_minus_out <= PORTS_CLR;
            downstreamOe_n       <= PORTS_OFF_N;
            upstream_plus_out    <= 1'b0;
            upstream_minus_out   <= 1'b0;
            upstreamOe_n         <= 1'b1;
            upstreamFifoReady    <= 1'b0;
        end else begin
            downstream_plus_out  <= {NUM_PORTS{fifoData[SYM_PLUS_BIT]}};
            downstream_minus_out <= {NUM_PORTS{fifoData[SYM_MINUS_BIT]}};
            downstreamOe_n       <= pop ? ~getsTraffic
                                        : PORTS_OFF_N;
            upstream_plus_out    <= upPlus;
            upstream_minus_out   <= upMinus;
            upstreamOe_n         <= !(upActive && !upstreamRxActive);
            upstreamFifoReady    <= fifoInReady;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync_n);

    property p_oc_power_off;
        !port_overcurrent_n[0] ##1 !port_overcurrent_n[0]
            |-> ##[2:3] port_power_switch_n[0];
    endproperty
    a_oc_power_off: assert property (p_oc_power_off)
        else $error("power stayed on during overcurrent");

    property p_oc_report;
        ocSync[1] && !globalMode |-> ##2 overcurrentStatus[1];
    endproperty
    a_oc_report: assert property (p_oc_report)
        else $error("overcurrent not reported");

    property p_connect;
        portEnabled[2] |=> !portConnectStatus_n[2];
    endproperty
    a_connect: assert property (p_connect)
        else $error("connect status missing for enabled port");

    property p_bus_ignores_sense;
        !selfPowered |=> localPowerGood;
    endproperty
    a_bus_ignores_sense: assert property (p_bus_ignores_sense)
        else $error("local sense used in bus-powered mode");

    property p_global_off;
        globalMode && anyOc |=> port_power_switch_n == PORTS_OFF_N;
    endproperty
    a_global_off: assert property (p_global_off)
        else $error("global overcurrent left a port powered");

    property p_unswitched;
        selfPowered && !switchedMode && !globalMode && !ocLatched[3]
            |=> !port_power_switch_n[3];
    endproperty
    a_unswitched: assert property (p_unswitched)
        else $error("unswitched port not powered");

    property p_ls_window;
        lsState == LS_IDLE && preambleSeen |-> ##[1:LS_BOUND] lsState == LS_ON;
    endproperty
    a_ls_window: assert property (p_ls_window)
        else $error("low-speed drivers late after preamble");

    property p_ls_blocked;
        lsState != LS_ON && portLowSpeed[0] |=> downstreamOe_n[0];
    endproperty
    a_ls_blocked: assert property (p_ls_blocked)
        else $error("low-speed port driven without preamble");

    property p_sof;
        sofSeen |=> frameTimer == '0;
    endproperty
    a_sof: assert property (p_sof)
        else $error("frame timer not restarted by start of frame");

    property p_repeat;
        pop && getsTraffic[1] |=> !downstreamOe_n[1]
            && downstream_plus_out[1] == $past(fifoData[SYM_PLUS_BIT]);
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("upstream symbol not repeated downstream");

    c_ls_packet: cover property (lsState == LS_ON ##[1:20] lsState == LS_IDLE);
    c_fifo_full: cover property (!fifoInReady);
    c_upstream: cover property (!upstreamOe_n);
    c_oc: cover property (anyOc ##1 overcurrentClear[0]);
endmodule // usb_hub_port_power_status
`default_nettype wire

/* bench/downstream_devices.sv */
`timescale 1ns/1ns
`default_nettype none
module downstream_devices
    import hub_pkg::*;
(
    // Bench commands
    input  wire logic                 holdOff,
    input  wire logic [NUM_PORTS-1:0] activeMask,
    input  wire logic [NUM_PORTS-1:0] plusVal,
    input  wire logic [NUM_PORTS-1:0] minusVal,
    // Lines toward the hub
    output logic                      downstreamTxReady,
    output logic      [NUM_PORTS-1:0] downstreamRxActive,
    output logic      [NUM_PORTS-1:0] downstream_plus_in,
    output logic      [NUM_PORTS-1:0] downstream_minus_in
);
    // Silent ports fall to the pull-down level, so stale data never shows
    always_comb begin
        downstreamTxReady   = !holdOff;
        downstreamRxActive  = activeMask;
        downstream_plus_in  = plusVal & activeMask;
        downstream_minus_in = minusVal & activeMask;
    end
endmodule // downstream_devices
`default_nettype wire

/* bench/usb_hub_port_power_status_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module usb_hub_port_power_status_tb;
    import hub_pkg::*;
    localparam int FLEN = 50;
    // Design inputs and outputs
    logic        clk, arst_n, selfP, swMode, glMode, testMode, sense;
    logic        sof, pre, upRx, upEop, upPIn, upMIn, hold;
    logic [3:0]  pwrReq, enReq, lowSpd, ocClr, ocPin_n, actM, pV, mV;
    logic        txRdy, pGood, upP, upM, upOe_n, fifoRdy;
    logic [3:0]  dnAct, dnPIn, dnMIn, ocStat, pwr_n, conn_n;
    logic [3:0]  dnP, dnM, dnOe_n, ocModel, seen, m;
    logic [13:0] fTimer;
    logic [2:0]  sym;
    logic [2:0]  q[$];
    int          miscompares, checksDone, p;

    usb_hub_port_power_status #(
        .FRAME_LEN(FLEN)
    ) u_usb_hub_port_power_status (
        .clk(clk), .arst_n(arst_n), .selfPowered(selfP),
        .switchedMode(swMode), .globalMode(glMode), .testMode(testMode),
        .local_power_sense(sense), .portPowerReq(pwrReq),
        .portEnableReq(enReq), .portLowSpeed(lowSpd),
        .overcurrentClear(ocClr), .overcurrentStatus(ocStat),
        .localPowerGood(pGood), .sofSeen(sof), .preambleSeen(pre),
        .frameTimer(fTimer), .port_overcurrent_n(ocPin_n),
        .port_power_switch_n(pwr_n), .portConnectStatus_n(conn_n),
        .upstreamRxActive(upRx), .upstreamEop(upEop),
        .upstream_plus_in(upPIn), .upstream_minus_in(upMIn),
        .upstream_plus_out(upP), .upstream_minus_out(upM),
        .upstreamOe_n(upOe_n), .upstreamFifoReady(fifoRdy),
        .downstreamTxReady(txRdy), .downstreamRxActive(dnAct),
        .downstream_plus_in(dnPIn), .downstream_minus_in(dnMIn),
        .downstream_plus_out(dnP), .downstream_minus_out(dnM),
        .downstreamOe_n(dnOe_n));

    downstream_devices u_downstream_devices (
        .holdOff(hold), .activeMask(actM), .plusVal(pV), .minusVal(mV),
        .downstreamTxReady(txRdy), .downstreamRxActive(dnAct),
        .downstream_plus_in(dnPIn), .downstream_minus_in(dnMIn));

    // Clock at 10 MHz
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [15:0] s, input logic [15:0] e);
        checksDone++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d miscompares=%0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Expected power pins from mode straps, requests and latched faults
    function automatic logic [3:0] expPwr_n();
        logic [3:0] on;
        on = glMode ? {4{pwrReq[0]}} : pwrReq;
        if (selfP && !swMode)
            on = 4'hF;
        return ~(on & ~ocModel);
    endfunction

    // One upstream symbol; gather which ports the hub drove for it
    task automatic push1(input logic [2:0] s, output logic [3:0] got);
        @(posedge clk);
        upRx <= 1'b1;
        {upEop, upPIn, upMIn} <= s;
        @(posedge clk);
        upRx <= 1'b0;
        got = 4'h0;
        repeat (5) begin
            @(negedge clk);
            got |= ~dnOe_n;
        end
    endtask

    // Watchdog well beyond the few hundred cycles the run needs
    initial begin
        #(5000 * 100);
        miscompares++;
        summarize();
    end

    initial begin
        void'($urandom(32'h9D10));
        {arst_n, selfP, swMode, glMode, sense, sof, pre} = '0;
        {upRx, upEop, upPIn, upMIn, hold, pwrReq, enReq} = '0;
        {lowSpd, ocClr, actM, pV, mV, ocModel} = '0;
        testMode = 1'b1;
        ocPin_n = 4'hF;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check({pwr_n, conn_n, dnOe_n, 3'h0, upOe_n}, 16'hFFF1);
        @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Every strap combination with random requests and sense level
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {selfP, swMode, glMode} <= i[2:0];
            pwrReq <= 4'($urandom);
            enReq <= 4'($urandom);
            sense <= 1'($urandom);
            repeat (2) @(posedge clk);
            @(negedge clk);
            check(pwr_n, expPwr_n());
            m = glMode ? {4{enReq[0]}} : enReq;
            check(conn_n, 4'(expPwr_n() | ~m));
            check(pGood, selfP ? sense : 1'b1);
        end
        // Fault trips one port, or all ports in global mode, then clears
        for (int g = 0; g < 2; g++) begin
            @(posedge clk);
            {selfP, swMode, glMode, pwrReq, enReq} <= {2'b11, g[0], 8'hFF};
            p = $urandom % 4;
            ocPin_n[p] <= 1'b0;
            for (int k = 0; k < 6 && pwr_n[p] !== 1'b1; k++)
                @(negedge clk);
            repeat (2) @(negedge clk);
            ocModel = g ? 4'hF : 4'h1 << p;
            check(pwr_n, expPwr_n());
            check(ocStat, ocModel);
            @(posedge clk);
            ocPin_n <= 4'hF;
            repeat (4) @(posedge clk);
            ocClr <= 4'hF;
            @(posedge clk);
            ocClr <= 4'h0;
            repeat (2) @(negedge clk);
            ocModel = 4'h0;
            check(ocStat, ocModel);
            check(pwr_n, expPwr_n());
        end
        // Frame timer restarts on a start-of-frame and wraps at its length
        @(posedge clk);
        {glMode, sof} <= 2'b01;
        @(posedge clk);
        sof <= 1'b0;
        @(negedge clk);
        check(fTimer, 0);
        repeat (60) @(posedge clk);
        @(negedge clk);
        check(fTimer, 60 % FLEN);
        // Devices talk upstream; the lowest active port wins
        for (int i = 0; i < 6; i++) begin
            m = 4'($urandom % 15 + 1);
            @(posedge clk);
            {actM, pV, mV} <= {m, 4'($urandom), 4'($urandom)};
            @(posedge clk);
            @(negedge clk);
            p = 0;
            while (!m[p])
                p++;
            check({upP, upM, upOe_n}, {pV[p], mV[p], 1'b0});
        end
        @(posedge clk);
        actM <= 4'h0;
        // Fill the FIFO past full with the far side stalled, then drain
        hold <= 1'b1;
        enReq <= 4'($urandom) | 4'h1;
        for (int i = 0; i < 6; i++) begin
            sym = 3'($urandom);
            @(posedge clk);
            upRx <= 1'b1;
            {upEop, upPIn, upMIn} <= sym;
            if (q.size() < FIFO_DEPTH)
                q.push_back(sym);
        end
        @(posedge clk);
        upRx <= 1'b0;
        repeat (2) @(negedge clk);
        check(fifoRdy, 1'b0);
        @(posedge clk);
        hold <= 1'b0;
        for (int k = 0; k < 12; k++) begin
            @(negedge clk);
            if (dnOe_n[0] === 1'b0 && q.size() > 0) begin
                sym = q.pop_front();
                check({dnP, dnM}, {{4{sym[1]}}, {4{sym[0]}}});
                check(dnOe_n, 4'(~enReq));
            end
        end
        check(q.size(), 0);
        // Low-speed port is skipped until a preamble, and after the EOP
        @(posedge clk);
        enReq <= 4'hF;
        lowSpd <= 4'h8;
        push1(3'b010, seen);
        check(seen, 4'h7);
        @(posedge clk);
        pre <= 1'b1;
        @(posedge clk);
        pre <= 1'b0;
        repeat (LS_EN_CYCLES) @(posedge clk);
        push1(3'b001, seen);
        check(seen, 4'hF);
        push1(3'b100, seen);
        push1(3'b010, seen);
        check(seen, 4'h7);
        summarize();
    end
endmodule // usb_hub_port_power_status_tb
`default_nettype wire
